// [design/adc_scan_pkg.sv]
// Purpose: shared constants and carriers of the ADC scan read sequencer.
// Assumes: 40 MHz system clock; two-wire link clocked by the bus master.
// Notes: timing counts follow from the clock period.
// Operation
// - with pin as reference, top differential pair converts lower channel minus ground
// - differential scan steps channel index by two up to the upper select limit
// - read starts with START, address, read bit; device acknowledges a good address
// - each result is two bytes: four high bits, then twelve bits MSB first
// - master acks to continue, nacks to finish; device releases data on nack
// - clock-source bit picks conversion clock mode; internal mode after reset
// - internal mode tracks on eighth rising edge, converts from ninth falling edge
// - internal mode holds clock low while converting, at most 0.3us per channel
// - results kept in a 12-bit memory, one entry per conversion, read first-in-first-out
// - reading past the last stored result wraps to the first one
// - internal mode returns only current results; fresh ones need a new read
// - pin in reference use is skipped in any multichannel scan
// - external mode tracks on ninth rising edge, converts two link clocks later
// - external mode sends result after high bits and repeats until a nack
// - scan 00 runs from input zero up to selection, capped at 11 or lower
// - scan 01 converts the selected input eight times
// - scan 10 runs up from input two or six to the selection
// - scan 11 converts once; in external mode 01 and 11 repeat endlessly
// - master acks each byte to continue; a nacked byte ends memory transmission
// - memory is readable only through a read cycle that converts
// - channel select resets to 0000; upper two bits zero on four-channel variant
// - single/differential bit: one single-ended, zero differential; resets to one
package adc_scan_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int STRETCH_PER_CH_NS = 300;
    // longest time rounds down, never below one cycle
    localparam int CONV_CYCLES = (STRETCH_PER_CH_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (STRETCH_PER_CH_NS / CLK_PERIOD_NS);
    localparam logic [3:0] EXT_CONV_DELAY_EDGES = 4'h2;

    // ************************************************************
    // frame layout and scan codes
    // ************************************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h55; // value is arbitrary
    localparam logic [3:0] FRAME_PAD = 4'hF;
    localparam logic [3:0] REPEAT_EXTRA = 4'h7; // eight conversions in all
    localparam logic [1:0] SCAN_UP = 2'h0;
    localparam logic [1:0] SCAN_REPEAT = 2'h1;
    localparam logic [1:0] SCAN_UPPER = 2'h2;
    localparam logic [1:0] SCAN_SINGLE = 2'h3;

    typedef struct packed {
        logic clockExt;
        logic [1:0] scan;
        logic [3:0] chan;
        logic single;
        logic refUse;
    } cfg_s;

    typedef struct packed {
        logic [3:0] channel;
        logic single;
        logic negIsGnd;
    } convReq_s;

    // power-up: internal clock, single-ended, one conversion on input zero
    localparam cfg_s RST_CFG = '{clockExt: 1'b0, scan: 2'h3, chan: 4'h0,
        single: 1'b1, refUse: 1'b0};

endpackage

// [design/adc_scan_read_sequencer.sv]
// Purpose: read-cycle sequencer of a multichannel 12-bit ADC on a two-wire link.
// Assumes: open-drain link pins; the converter answers within its window
//          after each convStart pulse.
// Notes: pins are oversampled; the link clock domain only counts link edges,
//        which pace external mode conversions.
`timescale 1ns/1ps
module adc_scan_read_sequencer #(
    parameter int NUM_CH = 12,
    parameter logic [3:0] UPPER_START = 4'h6
) (
    // system
    input wire logic clk,
    input wire logic resetn,
    // link clock domain
    input wire logic sclClk,
    // link pins
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOeN,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // configuration
    input wire logic cfgWrite,
    input wire adc_scan_pkg::cfg_s cfgIn,
    output adc_scan_pkg::cfg_s cfgState,
    output logic busy,
    // converter
    output logic trackStart,
    output logic convStart,
    output adc_scan_pkg::convReq_s convReq,
    input wire logic [11:0] convResult
);
    import adc_scan_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_AACK = 6'b000100,
        ST_CONV = 6'b001000,
        ST_TXD = 6'b010000,
        ST_MACK = 6'b100000
    } state_e;

    localparam int PW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [3:0] minCh(input logic [3:0] a, input logic [3:0] b);
        minCh = (a < b) ? a : b;
    endfunction

    function automatic logic [3:0] maxCh(input logic [3:0] a, input logic [3:0] b);
        maxCh = (a > b) ? a : b;
    endfunction

    function automatic logic [3:0] grayToBin(input logic [3:0] g);
        logic [3:0] b;
        b[3] = g[3];
        b[2] = b[3] ^ g[2];
        b[1] = b[2] ^ g[1];
        b[0] = b[1] ^ g[0];
        grayToBin = b;
    endfunction

    // ************************************************************
    // link clock domain: edge counter, gray coded for the crossing
    // ************************************************************
    logic [3:0] linkBinFf;
    logic [3:0] linkGrayFf;
    wire logic [3:0] nxt_linkBin = linkBinFf + 4'h1;

    // each rising link edge is one external-mode conversion clock
    always_ff @(posedge sclClk or negedge resetn) begin
        if (!resetn) begin
            linkBinFf <= 4'h0;
            linkGrayFf <= 4'h0;
        end else begin
            linkBinFf <= nxt_linkBin;
            linkGrayFf <= nxt_linkBin ^ (nxt_linkBin >> 1);
        end
    end

    // ************************************************************
    // synchronisers and pin edge detection
    // ************************************************************
    logic [3:0] grayS1Ff;
    logic [3:0] grayS2Ff;
    logic sclS1Ff;
    logic sclS2Ff;
    logic sclDFf;
    logic sdaS1Ff;
    logic sdaS2Ff;
    logic sdaDFf;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grayS1Ff <= 4'h0;
            grayS2Ff <= 4'h0;
            sclS1Ff <= 1'b1;
            sclS2Ff <= 1'b1;
            sclDFf <= 1'b1;
            sdaS1Ff <= 1'b1;
            sdaS2Ff <= 1'b1;
            sdaDFf <= 1'b1;
        end else begin
            grayS1Ff <= linkGrayFf;
            grayS2Ff <= grayS1Ff;
            sclS1Ff <= sclIn;
            sclS2Ff <= sclS1Ff;
            sclDFf <= sclS2Ff;
            sdaS1Ff <= sdaIn;
            sdaS2Ff <= sdaS1Ff;
            sdaDFf <= sdaS2Ff;
        end
    end

    wire logic sclRise = sclS2Ff & ~sclDFf;
    wire logic sclFall = ~sclS2Ff & sclDFf;
    wire logic startCond = sclS2Ff & sclDFf & sdaDFf & ~sdaS2Ff;
    wire logic stopCond = sclS2Ff & sclDFf & ~sdaDFf & sdaS2Ff;
    wire logic [3:0] linkCount = grayToBin(grayS2Ff);

    // ************************************************************
    // registers
    // ************************************************************
    state_e stateFf, nxt_state;
    cfg_s cfgFf;
    logic [3:0] bitCntFf, nxt_bitCnt;
    logic [7:0] shiftInFf, nxt_shiftIn;
    logic [15:0] txShiftFf, nxt_txShift;
    logic byteSelFf, nxt_byteSel;
    logic sdaDriveFf, nxt_sdaDrive;
    logic sclHoldFf, nxt_sclHold;
    logic [3:0] curChFf, nxt_curCh;
    logic [3:0] repLeftFf, nxt_repLeft;
    logic [4:0] timerFf, nxt_timer;
    logic [PW-1:0] wrPtrFf, nxt_wrPtr;
    logic [PW-1:0] rdPtrFf, nxt_rdPtr;
    logic [PW-1:0] lastPtrFf, nxt_lastPtr;
    logic [3:0] snapFf, nxt_snap;
    logic extPendFf, nxt_extPend;
    logic trackFf, nxt_track;
    logic convFf, nxt_conv;
    logic memWrite;
    logic [11:0] resultMem [NUM_CH];

    // ************************************************************
    // scan plan decoding
    // ************************************************************
    // four-channel variant forces upper select bits low
    wire logic [3:0] chanMasked = (NUM_CH == 4) ? {2'b00, cfgIn.chan[1:0]} : cfgIn.chan;
    wire logic [3:0] topSingle = 4'(NUM_CH - 1) - {3'b000, cfgFf.refUse};
    wire logic [3:0] topPair = 4'(NUM_CH - 2);
    wire logic [3:0] limSingle = minCh(cfgFf.chan, topSingle);
    wire logic [3:0] limDiff = minCh({cfgFf.chan[3:1], 1'b0}, topPair);
    wire logic [3:0] scanLimit = cfgFf.single ? limSingle : limDiff;
    wire logic [3:0] step = cfgFf.single ? 4'h1 : 4'h2;
    wire logic isRange = (cfgFf.scan == SCAN_UP) || (cfgFf.scan == SCAN_UPPER);
    // fixed-channel modes use the selection as is
    wire logic [3:0] startCh = (cfgFf.scan == SCAN_UP) ? 4'h0 :
        (cfgFf.scan == SCAN_UPPER) ? UPPER_START : cfgFf.chan;
    wire logic [3:0] endCh = (cfgFf.scan == SCAN_UP) ? scanLimit :
        (cfgFf.scan == SCAN_UPPER) ? maxCh(UPPER_START, scanLimit) : cfgFf.chan;
    wire logic [3:0] repLoad = (cfgFf.scan == SCAN_REPEAT) ? REPEAT_EXTRA : 4'h0;
    wire logic scanLast = (repLeftFf == 4'h0) && (!isRange || curChFf >= endCh);
    wire logic [3:0] advCh = (repLeftFf != 4'h0) ? curChFf : curChFf + step;
    wire logic [3:0] advRep = (repLeftFf != 4'h0) ? repLeftFf - 4'h1 : 4'h0;
    wire logic addrOk = (shiftInFf[6:0] == SLAVE_ADDR) && sdaS2Ff;
    wire logic extDue = ((linkCount - snapFf) >= EXT_CONV_DELAY_EDGES);
    wire logic timerDone = (timerFf == 5'(CONV_CYCLES - 1));
    wire logic [PW-1:0] rdNext = (rdPtrFf == lastPtrFf) ? '0 : rdPtrFf + 1'b1;

    // ************************************************************
    // protocol and scan sequencing
    // ************************************************************
    always_comb begin
        nxt_state = stateFf;
        nxt_bitCnt = bitCntFf;
        nxt_shiftIn = shiftInFf;
        nxt_txShift = txShiftFf;
        nxt_byteSel = byteSelFf;
        nxt_sdaDrive = sdaDriveFf;
        nxt_sclHold = sclHoldFf;
        nxt_curCh = curChFf;
        nxt_repLeft = repLeftFf;
        nxt_timer = timerFf;
        nxt_wrPtr = wrPtrFf;
        nxt_rdPtr = rdPtrFf;
        nxt_lastPtr = lastPtrFf;
        nxt_snap = snapFf;
        nxt_extPend = extPendFf;
        nxt_track = 1'b0;
        nxt_conv = 1'b0;
        memWrite = 1'b0;
        case (stateFf)
            ST_IDLE: begin
                nxt_sdaDrive = 1'b0;
            end
            ST_ADDR: begin
                if (sclRise) begin
                    nxt_shiftIn = {shiftInFf[6:0], sdaS2Ff};
                    nxt_bitCnt = bitCntFf + 4'h1;
                    // eighth rising edge: read bit sampled now
                    if (bitCntFf == 4'h7 && addrOk && !cfgFf.clockExt) begin
                        nxt_track = 1'b1;
                    end
                end else if (sclFall && bitCntFf == 4'h8) begin
                    if (shiftInFf[7:1] == SLAVE_ADDR && shiftInFf[0]) begin
                        nxt_sdaDrive = 1'b1;
                        nxt_state = ST_AACK;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_AACK: begin
                if (sclRise && cfgFf.clockExt) begin
                    nxt_track = 1'b1;
                    nxt_snap = linkCount;
                end else if (sclFall) begin
                    nxt_sdaDrive = 1'b0;
                    nxt_curCh = startCh;
                    nxt_repLeft = repLoad;
                    nxt_bitCnt = 4'h0;
                    nxt_byteSel = 1'b0;
                    nxt_wrPtr = '0;
                    nxt_timer = 5'h0;
                    if (cfgFf.clockExt) begin
                        nxt_txShift = {FRAME_PAD, 12'h000};
                        nxt_extPend = 1'b1;
                        nxt_state = ST_TXD;
                    end else begin
                        // stretching keeps the bus quiet while converting
                        nxt_sclHold = 1'b1;
                        nxt_conv = 1'b1;
                        nxt_state = ST_CONV;
                    end
                end
            end
            ST_CONV: begin
                nxt_timer = timerFf + 5'h1;
                if (timerDone) begin
                    memWrite = 1'b1;
                    nxt_wrPtr = wrPtrFf + 1'b1;
                    nxt_timer = 5'h0;
                    if (scanLast) begin
                        nxt_lastPtr = wrPtrFf;
                        nxt_rdPtr = '0;
                        nxt_sclHold = 1'b0;
                        nxt_txShift = {FRAME_PAD, resultMem[0]};
                        if (wrPtrFf == '0) begin
                            nxt_txShift = {FRAME_PAD, convResult};
                        end
                        nxt_state = ST_TXD;
                    end else begin
                        nxt_curCh = advCh;
                        nxt_repLeft = advRep;
                        nxt_conv = 1'b1;
                    end
                end
            end
            ST_TXD: begin
                nxt_sdaDrive = ~txShiftFf[15];
                if (extPendFf && extDue) begin
                    nxt_conv = 1'b1;
                    nxt_extPend = 1'b0;
                end
                if (sclFall) begin
                    if (bitCntFf == 4'h7) begin
                        nxt_sdaDrive = 1'b0;
                        nxt_state = ST_MACK;
                    end else if (cfgFf.clockExt && !byteSelFf && bitCntFf == 4'h3) begin
                        // result follows the four high bits directly
                        nxt_txShift = {convResult, 4'h0};
                        nxt_bitCnt = bitCntFf + 4'h1;
                    end else begin
                        nxt_txShift = {txShiftFf[14:0], 1'b0};
                        nxt_bitCnt = bitCntFf + 4'h1;
                    end
                end
            end
            ST_MACK: begin
                nxt_sdaDrive = 1'b0;
                if (sclRise) begin
                    nxt_snap = linkCount;
                    if (sdaS2Ff) begin
                        nxt_state = ST_IDLE;
                    end
                end else if (sclFall) begin
                    nxt_bitCnt = 4'h0;
                    nxt_state = ST_TXD;
                    if (!byteSelFf) begin
                        nxt_byteSel = 1'b1;
                        nxt_txShift = {txShiftFf[14:0], 1'b0};
                    end else begin
                        nxt_byteSel = 1'b0;
                        if (cfgFf.clockExt) begin
                            // loops the scan until the master stops it
                            nxt_curCh = scanLast ? startCh : advCh;
                            nxt_repLeft = scanLast ? repLoad : advRep;
                            nxt_txShift = {FRAME_PAD, 12'h000};
                            nxt_extPend = 1'b1;
                        end else begin
                            nxt_rdPtr = rdNext;
                            nxt_txShift = {FRAME_PAD, resultMem[rdNext]};
                        end
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // start and stop override any phase; stretch never outlives a frame
        if (startCond) begin
            nxt_state = ST_ADDR;
            nxt_bitCnt = 4'h0;
            nxt_sdaDrive = 1'b0;
            nxt_sclHold = 1'b0;
            nxt_extPend = 1'b0;
        end else if (stopCond) begin
            nxt_state = ST_IDLE;
            nxt_sdaDrive = 1'b0;
            nxt_sclHold = 1'b0;
            nxt_extPend = 1'b0;
        end
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateFf <= ST_IDLE;
            bitCntFf <= 4'h0;
            shiftInFf <= 8'h00;
            txShiftFf <= 16'hFFFF;
            byteSelFf <= 1'b0;
            sdaDriveFf <= 1'b0;
            sclHoldFf <= 1'b0;
            curChFf <= 4'h0;
            repLeftFf <= 4'h0;
            timerFf <= 5'h00;
            wrPtrFf <= '0;
            rdPtrFf <= '0;
            lastPtrFf <= '0;
            snapFf <= 4'h0;
            extPendFf <= 1'b0;
            trackFf <= 1'b0;
            convFf <= 1'b0;
        end else begin
            stateFf <= nxt_state;
            bitCntFf <= nxt_bitCnt;
            shiftInFf <= nxt_shiftIn;
            txShiftFf <= nxt_txShift;
            byteSelFf <= nxt_byteSel;
            sdaDriveFf <= nxt_sdaDrive;
            sclHoldFf <= nxt_sclHold;
            curChFf <= nxt_curCh;
            repLeftFf <= nxt_repLeft;
            timerFf <= nxt_timer;
            wrPtrFf <= nxt_wrPtr;
            rdPtrFf <= nxt_rdPtr;
            lastPtrFf <= nxt_lastPtr;
            snapFf <= nxt_snap;
            extPendFf <= nxt_extPend;
            trackFf <= nxt_track;
            convFf <= nxt_conv;
        end
    end

    // ************************************************************
    // configuration and result memory
    // ************************************************************
    // config loads only while idle so a scan never sees a torn setup
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfgFf <= RST_CFG;
        end else if (cfgWrite && stateFf == ST_IDLE) begin
            cfgFf <= '{clockExt: cfgIn.clockExt, scan: cfgIn.scan, chan: chanMasked,
                single: cfgIn.single, refUse: cfgIn.refUse};
        end
    end

    // memory content is unknown after power-up, so it has no reset
    always_ff @(posedge clk) begin
        if (memWrite) begin
            resultMem[wrPtrFf] <= convResult;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign sclOut = 1'b0;
    assign sclOeN = ~sclHoldFf;
    assign sdaOut = 1'b0;
    assign sdaOeN = ~sdaDriveFf;
    assign cfgState = cfgFf;
    assign busy = (stateFf != ST_IDLE);
    assign trackStart = trackFf;
    assign convStart = convFf;
    assign convReq.channel = curChFf;
    assign convReq.single = cfgFf.single;
    // top pair with pin as reference reads lower channel minus ground
    assign convReq.negIsGnd = cfgFf.refUse & ~cfgFf.single &
        ({curChFf[3:1], 1'b0} == topPair);

endmodule

// [testbench/adc_scan_monitor.sv]
// Purpose: port checker of the scan read sequencer.
// Assumes: one stretch holds at most twelve conversions.
// Notes: bound to every sequencer instance.
`timescale 1ns/1ps
module adc_scan_monitor #(
    parameter int NUM_CH = 12
) (
    // system
    input wire logic clk,
    input wire logic resetn,
    // link enables
    input wire logic sclOeN,
    input wire logic sdaOeN,
    // configuration
    input wire logic cfgWrite,
    input wire adc_scan_pkg::cfg_s cfgIn,
    input wire adc_scan_pkg::cfg_s cfgState,
    input wire logic busy,
    // converter
    input wire logic trackStart,
    input wire logic convStart,
    input wire adc_scan_pkg::convReq_s convReq
);
    import adc_scan_pkg::*;
    logic [3:0] lastCh_ff;
    logic inRun_ff;
    // channel of the previous conversion in the same stretch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lastCh_ff <= 4'h0;
            inRun_ff <= 1'b0;
        end else begin
            lastCh_ff <= convStart ? convReq.channel : lastCh_ff;
            inRun_ff <= convStart | (inRun_ff & ~sclOeN);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_stretch;
        $fell(sclOeN) && !cfgState.clockExt;
    endsequence
    sequence s_extTrack;
        trackStart && cfgState.clockExt;
    endsequence
    a_reset_cfg: assert property ($rose(resetn) |-> cfgState == RST_CFG)
        else $error("config not at reset value");
    a_cfg_load: assert property (!busy && cfgWrite |=> cfgState == $past(cfgIn))
        else $error("config not loaded");
    a_idle_free: assert property (!busy |-> sdaOeN && sclOeN)
        else $error("pin held while idle");
    a_stretch_len: assert property (s_stretch |-> ##[12:160] $rose(sclOeN))
        else $error("stretch length wrong");
    a_stretch_conv: assert property (s_stretch |-> ##[0:2] convStart)
        else $error("no conversion at stretch");
    a_track_conv: assert property (trackStart && !cfgState.clockExt |-> ##[1:200] convStart)
        else $error("tracking without conversion");
    a_ext_free: assert property (cfgState.clockExt |-> sclOeN)
        else $error("stretch in external mode");
    a_ext_delay: assert property (s_extTrack |=> !convStart [*8])
        else $error("external conversion too early");
    a_conv_hold: assert property (convStart && !cfgState.clockExt |=>
        (!convStart && $stable(convReq)) [*8])
        else $error("conversion request unstable");
    a_diff_step: assert property (convStart && inRun_ff && !convReq.single && !cfgState.scan[0] |->
        convReq.channel == lastCh_ff + 4'h2)
        else $error("differential step wrong");
    a_ref_skip: assert property (convStart && cfgState.refUse && convReq.single &&
        cfgState.scan != SCAN_SINGLE |-> convReq.channel != 4'(NUM_CH - 1))
        else $error("reference pin converted");
    a_top_gnd: assert property (convStart && cfgState.refUse && !convReq.single &&
        convReq.channel[3:1] == 3'(NUM_CH / 2 - 1) |-> convReq.negIsGnd)
        else $error("top pair not against ground");
endmodule
bind adc_scan_read_sequencer adc_scan_monitor #(.NUM_CH(NUM_CH)) mon (.clk(clk),
    .resetn(resetn), .sclOeN(sclOeN), .sdaOeN(sdaOeN), .cfgWrite(cfgWrite), .cfgIn(cfgIn),
    .cfgState(cfgState), .busy(busy), .trackStart(trackStart), .convStart(convStart),
    .convReq(convReq));

// [testbench/i2c_master_model.sv]
// Purpose: two-wire bus master reading the sequencer.
// Assumes: pulled-up wires resolved outside.
// Notes: clock period far below 60us keeps external mode valid.
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int HALF = 320
) (
    // resolved wires
    input wire logic scl,
    input wire logic sda,
    // pull-downs, high releases
    output logic sclDrv,
    output logic sdaDrv,
    // received bytes
    output logic [7:0] rxByte,
    output logic rxStb
);
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
        rxStb = 1'b0;
    end
    // data set mid-low, sampled late high; the stretch wait is bounded
    task automatic bitIo(input logic b, output logic r);
        #(HALF / 2) sdaDrv = b;
        #(HALF / 2) sclDrv = 1'b1;
        for (int i = 0; i < 400 && scl !== 1'b1; i++) #25;
        #(HALF) r = sda;
        sclDrv = 1'b0;
    endtask
    task automatic start();
        sdaDrv = 1'b1;
        sclDrv = 1'b1;
        #(HALF) sdaDrv = 1'b0;
        #(HALF) sclDrv = 1'b0;
    endtask
    task automatic stop();
        #(HALF / 2) sdaDrv = 1'b0;
        #(HALF / 2) sclDrv = 1'b1;
        #(HALF) sdaDrv = 1'b1;
        #(HALF);
    endtask
    task automatic addrByte(input logic [6:0] ad, output logic ack);
        logic [7:0] f;
        logic r;
        f = {ad, 1'b1};
        for (int i = 7; i >= 0; i--) bitIo(f[i], r);
        bitIo(1'b1, ack);
    endtask
    task automatic readByte(input logic nack);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) bitIo(1'b1, v[i]);
        bitIo(nack, r);
        rxByte = v;
        rxStb = ~rxStb;
    endtask
endmodule

// [testbench/tb.sv]
// Purpose: self-checking bench of the scan read sequencer.
// Assumes: converter stand-in answers at once.
// Notes: results encode count, kind and channel under a random key.
`timescale 1ns/1ps
module tb;
    import adc_scan_pkg::*;
    typedef logic [3:0] chq_t[$];
    logic clk = 1'b0, resetn = 1'b0, cfgWrite = 1'b0, ngExp = 1'b0, a;
    cfg_s cfgIn = RST_CFG, cfgState;
    logic sclOut, sclOeN, sdaOut, sdaOeN, busy, trackStart, convStart, mScl, mSda, rxStb;
    convReq_s convReq;
    logic [11:0] convResult = 12'h000, key = 12'h000;
    logic [3:0] convCnt = 4'h0;
    logic [7:0] rxByte, expQ[$];
    int error_cnt = 0, n_tests = 0, seed = 56;
    wire logic scl = mScl & (sclOeN | sclOut);
    wire logic sda = mSda & (sdaOeN | sdaOut);
    always #12.5 clk = ~clk;
    adc_scan_read_sequencer dut (.clk(clk), .resetn(resetn), .sclClk(scl), .sclIn(scl),
        .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .cfgWrite(cfgWrite), .cfgIn(cfgIn), .cfgState(cfgState), .busy(busy),
        .trackStart(trackStart), .convStart(convStart), .convReq(convReq),
        .convResult(convResult));
    i2c_master_model m (.scl(scl), .sda(sda), .sclDrv(mScl), .sdaDrv(mSda),
        .rxByte(rxByte), .rxStb(rxStb));
    // converter stand-in; the count marks each fresh conversion
    always @(posedge clk) begin
        if (convStart) begin
            convResult <= key ^ {convCnt, convReq.single, convReq.negIsGnd, 2'h0, convReq.channel};
            convCnt <= convCnt + 4'h1;
        end
    end
    task automatic check(input string nm, logic [11:0] seen, logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // each received byte is matched against the oldest note
    always @(rxStb) if (resetn) check("rx byte", {4'h0, rxByte}, {4'h0, expQ.pop_front()});
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic chq_t span(int lo, int st, int n);
        chq_t q;
        for (int i = 0; i < n; i++) q.push_back(4'(lo + i * st));
        return q;
    endfunction
    function automatic cfg_s mk(logic e, logic [1:0] s, logic [3:0] c, logic g, logic f);
        return {e, s, c, g, f};
    endfunction
    // one read cycle; internal results wrap, external ones are fresh
    task automatic runScan(input cfg_s c, chq_t ch, int nRd);
        logic [3:0] base, k;
        logic [11:0] r;
        @(negedge clk) cfgIn = c;
        cfgWrite = 1'b1;
        @(negedge clk) cfgWrite = 1'b0;
        key = 12'($random(seed));
        base = convCnt;
        m.start();
        m.addrByte(SLAVE_ADDR, a);
        check("address ack", {11'h0, a}, 12'h000);
        for (int i = 0; i < nRd; i++) begin
            k = base + 4'(c.clockExt ? i : i % ch.size());
            r = key ^ {k, c.single, ngExp, 2'h0, ch[i % ch.size()]};
            expQ.push_back({FRAME_PAD, r[11:8]});
            expQ.push_back(r[7:0]);
            m.readByte(1'b0);
            m.readByte(i == nRd - 1);
        end
        m.stop();
        #1000 check("idle", {11'h0, busy}, 12'h000);
        $display("test done scan %h chan %h ext %b", c.scan, c.chan, c.clockExt);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        repeat (3) @(negedge clk);
        check("reset cfg", {4'h0, cfgState}, {4'h0, RST_CFG});
        m.start();
        m.addrByte(SLAVE_ADDR ^ 7'h01, a);
        check("foreign ack", {11'h0, a}, 12'h001);
        m.stop();
        runScan(mk(0, SCAN_SINGLE, 4'h5, 1, 0), span(5, 0, 1), 2);
        runScan(mk(0, SCAN_UP, 4'h2, 1, 0), span(0, 1, 3), 4);
        runScan(mk(0, SCAN_UP, 4'hF, 1, 1), span(0, 1, 11), 11);
        runScan(mk(0, SCAN_REPEAT, 4'h3, 1, 0), span(3, 0, 8), 8);
        runScan(mk(0, SCAN_UPPER, 4'h9, 1, 0), span(6, 1, 4), 4);
        runScan(mk(0, SCAN_UPPER, 4'h2, 1, 0), span(6, 1, 1), 2);
        runScan(mk(0, SCAN_UP, 4'h4, 0, 0), span(0, 2, 3), 3);
        ngExp = 1'b1;
        runScan(mk(0, SCAN_SINGLE, 4'hA, 0, 1), span(10, 0, 1), 1);
        ngExp = 1'b0;
        runScan(mk(1, SCAN_SINGLE, 4'h1, 1, 0), span(1, 0, 1), 3);
        runScan(mk(1, SCAN_REPEAT, 4'h2, 1, 0), span(2, 0, 1), 2);
        report_and_stop();
    end
    initial begin
        #2000000 error_cnt++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
